// ### spicc_pkg.sv
// Shared constants for the serial interface configuration core
package spicc_pkg;

	// Register byte offsets
	localparam logic [7:0] SPICC_OFF_MAIN   = 8'h00;
	localparam logic [7:0] SPICC_OFF_AUX    = 8'h04;
	localparam logic [7:0] SPICC_OFF_STATUS = 8'h0c;
	localparam logic [7:0] SPICC_OFF_PRESC  = 8'h10;

	// Reset values
	localparam logic [31:0] SPICC_MAIN_RST  = 32'h1c000000;
	localparam logic [31:0] SPICC_AUX_RST   = 32'h00000000;
	localparam logic [7:0]  SPICC_PRESC_RST = 8'h00;

	// Software-writable bits of each register
	// Both bits of the frame format field are writable
	localparam logic [31:0] SPICC_MAIN_WMASK  = 32'h05ffffdf;
	localparam logic [31:0] SPICC_AUX_WMASK   = 32'h00000006;
	localparam logic [31:0] SPICC_PRESC_WMASK = 32'h000000fe;

	// Field positions in the main control register
	localparam int SPICC_WIDTH_LSB = 0;
	localparam int SPICC_POL_BIT   = 6;
	localparam int SPICC_PHA_BIT   = 7;
	localparam int SPICC_RATE_LSB  = 8;
	localparam int SPICC_CMDW_LSB  = 16;
	localparam int SPICC_FRF_LSB   = 21;
	localparam int SPICC_MODE_LSB  = 23;
	localparam int SPICC_SEL1_BIT  = 26;

	// Field positions in the auxiliary control register
	localparam int SPICC_EN_BIT    = 1;
	localparam int SPICC_ROLE_BIT  = 2;

	// Smallest usable prescale divisor
	localparam logic [7:0] SPICC_PRESC_MIN = 8'h02;

	// Frame format codes
	localparam logic [1:0] SPICC_FRF_STD  = 2'h0;
	localparam logic [1:0] SPICC_FRF_CMD3 = 2'h2;

	// AXI response codes
	localparam logic [1:0] SPICC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SPICC_RESP_SLVERR = 2'h2;

endpackage

// ### spicc_core.sv
// Register block and bit-rate generator of the serial interface
`timescale 1ns/1ps
// Summary of operation
// R1 - Frame length is width field plus one
// R2 - Bit 6 sets serial clock idle level in standard format, idle is low otherwise
// R3 - Bit 7 selects the clock phase
// R4 - Bit rate is clock over divisor times rate field plus one
// R5 - Command length is command field plus one
// R6 - Format field: 0 standard, 2 three-wire
// R7 - Bits 24:23 pick master transfer mode
// R8 - Bit 26 drives slave one select, resets high
// R9 - Aux bit 1 enables port, resets off
// R10 - Aux bit 2 picks role, resets master
// R11 - Reserved bits ignore writes, read fixed values
module spicc_core
	import spicc_pkg::*;
#(
	parameter int ADDR_W = 8                // Byte address width
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Configuration seen by the transfer logic
	output logic [5:0]             frame_bits,
	output logic [5:0]             command_bits,
	output logic [1:0]             frame_format_select,
	output logic [1:0]             master_transfer_mode,
	output logic                   clock_sample_phase,
	output logic                   slave_one_select_n,
	output logic                   serial_port_enable,
	output logic                   role_select,
	// Serial clock and bit-rate strobe
	output logic                   serial_clk,
	output logic                   bit_tick
);

	// Register storage
	logic [31:0]       main_q;            // Main control register
	logic [31:0]       aux_q;             // Auxiliary control register
	logic [7:0]        presc_q;           // Prescale divisor

	// Write channel holding
	logic              aw_held_q;         // Write address captured
	logic              w_held_q;          // Write data captured
	logic [ADDR_W-1:0] waddr_q;           // Captured write address
	logic [31:0]       wdata_q;           // Captured write data
	logic [3:0]        wstrb_q;           // Captured byte strobes
	logic              bvalid_q;          // Write answer pending
	logic [1:0]        bresp_q;           // Write answer code

	// Read channel state
	logic              rvalid_q;          // Read answer pending
	logic [31:0]       rdata_q;           // Read answer data
	logic [1:0]        rresp_q;           // Read answer code

	// Bit-rate generator state
	logic [15:0]       div_cnt_q;         // Position within one bit
	logic              sclk_q;            // Serial clock level
	logic              tick_q;            // One-cycle bit strobe
	logic              run_q;             // Generator active

	// Combinational helpers
	logic              do_write;          // Both halves of a write held
	logic [31:0]       strb_mask;         // Byte strobes as a bit mask
	logic [15:0]       bit_period;        // Clocks per serial bit
	logic [15:0]       half_period;       // Clocks in first half
	logic              gen_ok;            // Divider setting usable
	logic              idle_level;        // Clock level between bits

	// A write proceeds once address and data are both in hand
	assign do_write = aw_held_q && w_held_q && !bvalid_q;

	// Expand byte strobes to a per-bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			strb_mask[i*8 +: 8] = {8{wstrb_q[i]}};
		end
	end

	// Write address: accept once, hold until the write completes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			waddr_q   <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			waddr_q   <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	// Write data: accepted independently of the address
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	// Ready only while the matching half is not yet held
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			// Drop ready on the accepting edge, reopen after answer
			s_axi_awready <= !aw_held_q && !bvalid_q &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_q && !bvalid_q &&
				!(s_axi_wvalid && s_axi_wready);
		end
	end

	// Write answer: OKAY for mapped words, SLVERR otherwise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= SPICC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			if (waddr_q[7:0] == SPICC_OFF_MAIN ||
				waddr_q[7:0] == SPICC_OFF_AUX ||
				waddr_q[7:0] == SPICC_OFF_PRESC ||
				waddr_q[7:0] == SPICC_OFF_STATUS) begin
				bresp_q <= SPICC_RESP_OKAY;
			end else begin
				bresp_q <= SPICC_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Main control register; only writable fields take new data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			main_q <= SPICC_MAIN_RST;           // [R8] [R11]
		end else if (do_write && waddr_q[7:0] == SPICC_OFF_MAIN) begin
			// Reserved bits keep their fixed values
			main_q <= (main_q & ~(SPICC_MAIN_WMASK & strb_mask)) |
				(wdata_q & SPICC_MAIN_WMASK & strb_mask); // [R11]
		end
	end

	// Auxiliary control register: enable and role
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aux_q <= SPICC_AUX_RST;             // [R9] [R10]
		end else if (do_write && waddr_q[7:0] == SPICC_OFF_AUX) begin
			aux_q <= (aux_q & ~(SPICC_AUX_WMASK & strb_mask)) |
				(wdata_q & SPICC_AUX_WMASK & strb_mask); // [R11]
		end
	end

	// Prescale divisor; bit 0 is forced low so it stays even
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			presc_q <= SPICC_PRESC_RST;
		end else if (do_write && waddr_q[7:0] == SPICC_OFF_PRESC &&
			wstrb_q[0]) begin
			presc_q <= wdata_q[7:0] & SPICC_PRESC_WMASK[7:0]; // [R4]
		end
	end

	// Read path: one answer at a time, data one edge after address
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			rvalid_q      <= 1'b0;
			rdata_q       <= '0;
			rresp_q       <= SPICC_RESP_OKAY;
		end else begin
			s_axi_arready <= !rvalid_q &&
				!(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rresp_q  <= SPICC_RESP_OKAY;
				// Address decode
				if (s_axi_araddr[7:0] == SPICC_OFF_MAIN) begin
					rdata_q <= main_q;           // [R11]
				end else if (s_axi_araddr[7:0] == SPICC_OFF_AUX) begin
					rdata_q <= aux_q;
				end else if (s_axi_araddr[7:0] == SPICC_OFF_PRESC) begin
					rdata_q <= {24'h000000, presc_q};
				end else if (s_axi_araddr[7:0] == SPICC_OFF_STATUS) begin
					// Live generator state
					rdata_q <= {29'h00000000, tick_q, sclk_q, run_q};
				end else begin
					// Unmapped words read zero with an error
					rdata_q <= '0;
					rresp_q <= SPICC_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Bit period is divisor times one plus rate field
	assign bit_period = 16'(presc_q) *
		(16'(main_q[SPICC_RATE_LSB +: 8]) + 16'h0001); // [R4]
	assign half_period = {1'b0, bit_period[15:1]};
	// An even divisor below two cannot form a clock
	assign gen_ok = presc_q >= SPICC_PRESC_MIN;   // [R4]
	// Idle level matters only for the standard format
	assign idle_level = (main_q[SPICC_FRF_LSB +: 2] == SPICC_FRF_STD) ?
		main_q[SPICC_POL_BIT] : 1'b0;            // [R2] [R6]

	// Generator runs only when enabled as master
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
		end else begin
			run_q <= aux_q[SPICC_EN_BIT] && !aux_q[SPICC_ROLE_BIT] &&
				gen_ok;                          // [R9] [R10]
		end
	end

	// Divider counter wraps at the bit period
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_cnt_q <= '0;
		end else if (!run_q) begin
			div_cnt_q <= '0;
		end else if (div_cnt_q >= bit_period - 16'h0001) begin
			// Also catches a period shortened mid-count
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// Bit strobe once per full period
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= run_q &&
				(div_cnt_q >= bit_period - 16'h0001); // [R4]
		end
	end

	// Serial clock leaves idle in the first half of each bit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
		end else if (!run_q) begin
			sclk_q <= idle_level;                // [R2]
		end else begin
			sclk_q <= (div_cnt_q < half_period) ?
				~idle_level : idle_level;        // [R4]
		end
	end

	// Decoded configuration for the transfer logic
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frame_bits           <= '0;
			command_bits         <= '0;
			frame_format_select  <= SPICC_FRF_STD;
			master_transfer_mode <= '0;
			clock_sample_phase   <= 1'b0;
			slave_one_select_n   <= 1'b1;
			serial_port_enable   <= 1'b0;
			role_select          <= 1'b0;
		end else begin
			// Lengths are field plus one; low codes are reserved
			frame_bits   <= {1'b0, main_q[SPICC_WIDTH_LSB +: 5]} +
				6'h01;                           // [R1]
			command_bits <= {1'b0, main_q[SPICC_CMDW_LSB +: 5]} +
				6'h01;                           // [R5]
			frame_format_select  <= main_q[SPICC_FRF_LSB +: 2]; // [R6]
			master_transfer_mode <= main_q[SPICC_MODE_LSB +: 2]; // [R7]
			clock_sample_phase   <= main_q[SPICC_PHA_BIT]; // [R3]
			slave_one_select_n   <= main_q[SPICC_SEL1_BIT]; // [R8]
			serial_port_enable   <= aux_q[SPICC_EN_BIT]; // [R9]
			role_select          <= aux_q[SPICC_ROLE_BIT]; // [R10]
		end
	end

	// Bus answers and serial outputs straight from flops
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;
	assign serial_clk   = sclk_q;
	assign bit_tick     = tick_q;

endmodule // spicc_core

// ### spicc_core_sva.sv
// Port checker for the serial configuration core
`timescale 1ns/1ps
module spicc_core_chk (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [5:0] frame_bits,
	input wire logic       slave_one_select_n,
	input wire logic       serial_port_enable,
	input wire logic       role_select,
	input wire logic       bit_tick
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// First edge after release still shows the reset values
	sel_reset_a: assert property ($past(rst) |-> slave_one_select_n)
		else $error("slave select low right after reset");
	en_reset_a: assert property ($past(rst) |-> !serial_port_enable)
		else $error("port enabled right after reset");
	role_reset_a: assert property ($past(rst) |-> !role_select)
		else $error("slave role right after reset");
	// Reserved codes still give a length of one to three bits
	width_range_a: assert property (
		!$past(rst) |-> frame_bits inside {[1:32]})
		else $error("frame length out of range");
	// Lag of the run flag is one clock, four is a safe margin
	tick_off_a: assert property (!serial_port_enable [*4] |-> !bit_tick)
		else $error("bit strobe while disabled");
	slave_tick_a: assert property (role_select [*4] |-> !bit_tick)
		else $error("bit strobe in slave role");
	// Shortest bit period is two clocks
	tick_pulse_a: assert property (bit_tick |=> !bit_tick)
		else $error("bit strobe wider than one clock");
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken during response");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
	tick_c: cover property (bit_tick);
	slave_c: cover property (role_select && serial_port_enable);
	read_c: cover property (s_axi_rvalid);
endmodule // spicc_core_chk

bind spicc_core spicc_core_chk i_chk (
	.clk_sys            (clk_sys),
	.rst                (rst),
	.s_axi_awready      (s_axi_awready),
	.s_axi_bvalid       (s_axi_bvalid),
	.s_axi_arready      (s_axi_arready),
	.s_axi_rvalid       (s_axi_rvalid),
	.frame_bits         (frame_bits),
	.slave_one_select_n (slave_one_select_n),
	.serial_port_enable (serial_port_enable),
	.role_select        (role_select),
	.bit_tick           (bit_tick)
);

// ### spicc_peer.sv
// Serial peer that counts clock edges on the link
`timescale 1ns/1ps
module spicc_peer (
	input wire logic serial_clk,
	output int       edge_count
);
	int count_q = 0;                        // Edges seen so far
	// Each level change is one edge seen by the peer
	always @(serial_clk) begin
		count_q <= count_q + 1;
	end
	// One driver for the count handed to the bench
	assign edge_count = count_q;
endmodule // spicc_peer

// ### testbench.sv
// Self-checking bench for the serial configuration core
`timescale 1ns/1ps
module testbench;
	import spicc_pkg::*;
	// Row: address, write, readback, response, length, select, en/role
	typedef struct {
		logic [7:0] a; logic [31:0] w, r; logic [1:0] rs;
		logic [5:0] fb; logic sel; logic [1:0] er;
	} spicc_row_t;
	spicc_row_t rows [6] = '{
		'{8'h00, 32'hffffffff, 32'h1dffffdf, 2'h0, 6'h20, 1'b1, 2'h0},
		'{8'h00, 32'h00000003, 32'h18000003, 2'h0, 6'h04, 1'b0, 2'h0},
		'{8'h04, 32'hffffffff, 32'h00000006, 2'h0, 6'h04, 1'b0, 2'h3},
		'{8'h40, 32'hffffffff, 32'h00000000, 2'h2, 6'h04, 1'b0, 2'h3},
		'{8'h04, 32'h00000000, 32'h00000000, 2'h0, 6'h04, 1'b0, 2'h0},
		'{8'h10, 32'h000000ff, 32'h000000fe, 2'h0, 6'h04, 1'b0, 2'h0}};
	logic        clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, bit_tick;
	logic        clock_sample_phase, slave_one_select_n, serial_clk;
	logic        serial_port_enable, role_select;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [1:0]  frame_format_select, master_transfer_mode;
	logic [5:0]  frame_bits, command_bits;
	int          miscompares, comparisons, edge_count, n, m, e0;
	spicc_core i_dut (
		.clk_sys              (clk_sys),
		.rst                  (rst),
		.s_axi_awaddr         (s_axi_awaddr),
		.s_axi_awvalid        (s_axi_awvalid),
		.s_axi_awready        (s_axi_awready),
		.s_axi_wdata          (s_axi_wdata),
		.s_axi_wstrb          (s_axi_wstrb),
		.s_axi_wvalid         (s_axi_wvalid),
		.s_axi_wready         (s_axi_wready),
		.s_axi_bresp          (s_axi_bresp),
		.s_axi_bvalid         (s_axi_bvalid),
		.s_axi_bready         (s_axi_bready),
		.s_axi_araddr         (s_axi_araddr),
		.s_axi_arvalid        (s_axi_arvalid),
		.s_axi_arready        (s_axi_arready),
		.s_axi_rdata          (s_axi_rdata),
		.s_axi_rresp          (s_axi_rresp),
		.s_axi_rvalid         (s_axi_rvalid),
		.s_axi_rready         (s_axi_rready),
		.frame_bits           (frame_bits),
		.command_bits         (command_bits),
		.frame_format_select  (frame_format_select),
		.master_transfer_mode (master_transfer_mode),
		.clock_sample_phase   (clock_sample_phase),
		.slave_one_select_n   (slave_one_select_n),
		.serial_port_enable   (serial_port_enable),
		.role_select          (role_select),
		.serial_clk           (serial_clk),
		.bit_tick             (bit_tick)
	);
	spicc_peer i_peer (.serial_clk(serial_clk), .edge_count(edge_count));
	// 250 MHz system clock
	always #2 clk_sys = ~clk_sys;
	task automatic results;
		$display("checks %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	// A bound that runs out counts as a mismatch and ends the run
	task automatic hang(input int k);
		if (k >= 60) begin
			miscompares++;
			results();
		end
	endtask
	// Write: address and data together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		hang(k);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		hang(k);
		{rdv, rsp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Waits for the next strobe, returning the clocks it took
	task automatic tick(output int k);
		for (k = 1; k < 60; k++) begin
			@(posedge clk_sys);
			if (bit_tick === 1'b1) break;
		end
	endtask
	initial begin
		{clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h01 << 3;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_wstrb, miscompares, comparisons} = 4'hf << 64;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].a, rows[i].w);
			chk("bresp", rows[i].rs, rsp);
			rd(rows[i].a);
			chk("rdata", rows[i].r, rdv);
			chk("rresp", rows[i].rs, rsp);
			chk("frame_bits", rows[i].fb, frame_bits);
			chk("select", rows[i].sel, slave_one_select_n);
			chk("en_role", rows[i].er, {serial_port_enable, role_select});
		end
		$display("register rows done");
		for (m = 0; m < 4; m++) begin
			wr(8'h00, 32'(m * 32'h800000 + (m + 3) * 32'h10000 + m % 2 * 8'h80 + 3));
			chk("mode", m, master_transfer_mode);
			chk("command_bits", m + 4, command_bits);
			chk("phase", m % 2, clock_sample_phase);
			chk("format", 0, frame_format_select);
		end
		$display("mode codes done");
		wr(8'h10, 32'h4);
		wr(8'h00, 32'h00000247);
		chk("idle_high", 1, serial_clk);
		wr(8'h04, 32'h2);
		tick(n);
		// One full bit later the peer has seen exactly two edges
		e0 = edge_count;
		tick(n);
		chk("bit_period", 12, n);
		chk("peer_edges", 2, edge_count - e0);
		wr(8'h04, 32'h6);
		repeat (4) @(posedge clk_sys);
		tick(n);
		chk("slave_quiet", 60, n);
		// Status shows generator stopped, clock at its high idle level
		rd(8'h0c);
		chk("status", 32'h2, rdv);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h00400047);
		repeat (4) @(posedge clk_sys);
		chk("idle_three_wire", 0, serial_clk);
		chk("format_three_wire", 2, frame_format_select);
		$display("bit rate done");
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(8'h00);
		chk("main_reset", 32'h1c000000, rdv);
		rd(8'h04);
		chk("aux_reset", 32'h0, rdv);
		$display("reset done");
		results();
	end
endmodule // testbench
